// ---- inc/jie_pkg.sv ----
// constants and types for the jump and increment execution block
package jie_pkg;
   localparam int          INSTR_W        = 14;
   localparam int          PC_W           = 13;
   localparam int          DATA_W         = 8;
   localparam int          FADDR_W        = 7;
   localparam int          QUARTERS       = 4;
   localparam int          OSC_PERIOD_NS  = 50;
   localparam int          TCY_NS         = QUARTERS * OSC_PERIOD_NS;
   localparam int          TCY_CLKS       = TCY_NS / OSC_PERIOD_NS;
   localparam logic [2:0]  JUMP_OPC       = 3'h5;
   localparam int          JUMP_OPC_LSB   = 11;
   localparam logic [5:0]  INCR_OPC       = 6'h0a;
   localparam int          INCR_OPC_LSB   = 8;
   localparam int          DEST_BIT       = 7;
   localparam int          LATCH_HI_BIT   = 4;
   localparam int          LATCH_LO_BIT   = 3;
   localparam logic [1:0]  PHASE_RST      = 2'h0;
   localparam logic [12:0] PC_RST         = 13'h0000;
   localparam logic [7:0]  DATA_RST       = 8'h00;
   typedef enum logic [3:0] {
      JIE_PH_DECODE  = 4'h1,
      JIE_PH_READ    = 4'h2,
      JIE_PH_PROCESS = 4'h4,
      JIE_PH_WRITE   = 4'h8
   } jie_phase_t;
endpackage : jie_pkg

// ---- src/jie_quarter_gen.sv ----
// quarter phase generator: four oscillator periods per instruction cycle
`timescale 1ns/10ps
module jie_quarter_gen (
   input  wire logic   clock,
   input  wire logic   sys_rst,
   output jie_pkg::jie_phase_t phase,
   output logic        cycleEnd
);
   logic [1:0] count;
   wire  [1:0] next_count = count + 2'h1;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         count <= jie_pkg::PHASE_RST;
      end else begin
         count <= next_count; // RQ9
      end
   end

   assign phase    = jie_pkg::jie_phase_t'(4'h1 << count);
   assign cycleEnd = (count == 2'(jie_pkg::TCY_CLKS - 1));

   property p_four_periods;
      @(posedge clock) disable iff (sys_rst)
         cycleEnd |=> !cycleEnd [*3] ##1 cycleEnd;
   endproperty
   a_four_periods : assert property (p_four_periods) // RQ9
      else $error("instruction cycle not four periods");
endmodule : jie_quarter_gen

// ---- src/jie_exec.sv ----
// execution of absolute jump and register increment over four quarter phases
// Summary of operation
// RQ1 - absolute jump loads literal into pc bits 10:0
// RQ2 - pc bits 12:11 come from latch bits 4:3
// RQ3 - jump takes two cycles, flags untouched
// RQ4 - second jump cycle does nothing, discards fetch
// RQ5 - increment decodes as 001010, d bit, address
// RQ6 - d=0 writes working register, d=1 writes file
// RQ7 - increment updates zero flag only
// RQ8 - increment completes in one instruction cycle; a d=1 file write lands at the close of the next cycle's decode phase
// RQ9 - instruction cycle is four oscillator periods
`timescale 1ns/10ps
module jie_exec (
   input  wire logic        clock,
   input  wire logic        sys_rst,
   input  wire logic [13:0] instrWord,
   input  wire logic [7:0]  pcHighLatch,
   input  wire logic [7:0]  fileRdData,
   output logic [6:0]       fileAddr,
   output logic             fileRdEn,
   output logic [7:0]       fileWrData,
   output logic             fileWrEn,
   output logic [7:0]       workReg,
   output logic             zeroFlag,
   output logic             zeroWrEn,
   output logic [12:0]      pcValue,
   output logic             pcLoad,
   output logic             fetchFlush,
   output logic             quarterPhaseOne,
   output logic             cycleStart
);
   jie_pkg::jie_phase_t phase;
   logic                cycleEnd;
   logic [13:0]         instrHeld;
   logic                flushCycle;
   logic [7:0]          incData;
   logic [7:0]          incResult;

   jie_quarter_gen u_quarter (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .phase    (phase),
      .cycleEnd (cycleEnd)
   );

   // word held from the decode phase on, so later fetch changes in the cycle are harmless
   wire        inDecode    = (phase == jie_pkg::JIE_PH_DECODE);
   wire        inRead      = (phase == jie_pkg::JIE_PH_READ);
   wire        inProcess   = (phase == jie_pkg::JIE_PH_PROCESS);
   wire        inWrite     = (phase == jie_pkg::JIE_PH_WRITE);
   wire        isJump      = (instrHeld[13:jie_pkg::JUMP_OPC_LSB] == jie_pkg::JUMP_OPC); // RQ1
   wire        isIncr      = (instrHeld[13:jie_pkg::INCR_OPC_LSB] == jie_pkg::INCR_OPC); // RQ5
   // read launched from the incoming word, so the data stands in the read phase
   wire        fetchIsIncr = (instrWord[13:jie_pkg::INCR_OPC_LSB] == jie_pkg::INCR_OPC); // RQ5
   wire [6:0]  fetchAddr   = instrWord[6:0];
   wire        destFile    = instrHeld[jie_pkg::DEST_BIT];
   // cycle after a jump is dead: its word was fetched before the pc moved
   wire        active      = !flushCycle; // RQ4
   wire [6:0]  decAddr     = instrHeld[6:0];
   wire [12:0] jumpTarget  = {pcHighLatch[jie_pkg::LATCH_HI_BIT:jie_pkg::LATCH_LO_BIT],
                              instrHeld[10:0]}; // RQ1 RQ2
   wire [7:0]  sumValue    = incData + 8'h01;
   wire        doRead      = inDecode && active && fetchIsIncr;
   wire        doJumpWr    = inWrite && active && isJump;
   wire        doIncWr     = inWrite && active && isIncr; // RQ8
   wire [6:0]  next_addr   = inDecode ? fetchAddr : decAddr;
   wire        next_flush  = cycleEnd ? (active && isJump) : flushCycle; // RQ3

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         instrHeld  <= 14'h0000;
         flushCycle <= 1'b0;
      end else begin
         if (inDecode) instrHeld <= instrWord;
         flushCycle <= next_flush;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         incData   <= jie_pkg::DATA_RST;
         incResult <= jie_pkg::DATA_RST;
      end else begin
         if (inRead && active && isIncr) incData <= fileRdData;
         if (inProcess && active && isIncr) incResult <= sumValue;
      end
   end

   // register file side; each strobe is one clock wide
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         fileAddr   <= 7'h00;
         fileRdEn   <= 1'b0;
         fileWrData <= jie_pkg::DATA_RST;
         fileWrEn   <= 1'b0;
      end else begin
         fileAddr   <= next_addr;
         fileRdEn   <= doRead; // RQ5
         fileWrEn   <= doIncWr && destFile; // RQ6
         fileWrData <= doIncWr ? incResult : fileWrData;
      end
   end

   // working register and zero flag, written only in the write phase of an increment
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         workReg  <= jie_pkg::DATA_RST;
         zeroFlag <= 1'b0;
         zeroWrEn <= 1'b0;
      end else begin
         if (doIncWr && !destFile) workReg <= incResult; // RQ6
         zeroWrEn <= doIncWr; // RQ7
         if (doIncWr) zeroFlag <= (incResult == 8'h00); // RQ7
      end
   end

   // pc and cycle markers; a jump never reaches the flag logic above
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         pcValue         <= jie_pkg::PC_RST;
         pcLoad          <= 1'b0;
         fetchFlush      <= 1'b0;
         quarterPhaseOne <= 1'b0;
         cycleStart      <= 1'b0;
      end else begin
         pcLoad          <= doJumpWr; // RQ3
         if (doJumpWr) pcValue <= jumpTarget;
         fetchFlush      <= doJumpWr; // RQ4
         quarterPhaseOne <= cycleEnd; // RQ9
         cycleStart      <= cycleEnd;
      end
   end

   // checks on what the block drives
   property p_jump_target;
      @(posedge clock) disable iff (sys_rst)
         doJumpWr |=> pcLoad && pcValue == $past(jumpTarget);
   endproperty
   a_jump_target : assert property (p_jump_target) // RQ1
      else $error("jump target wrong");

   property p_jump_high;
      @(posedge clock) disable iff (sys_rst)
         doJumpWr |=> pcValue[12:11] == $past(pcHighLatch[4:3]);
   endproperty
   a_jump_high : assert property (p_jump_high) // RQ2
      else $error("pc high bits not from latch");

   property p_jump_noflag;
      @(posedge clock) disable iff (sys_rst)
         doJumpWr |=> !zeroWrEn;
   endproperty
   a_jump_noflag : assert property (p_jump_noflag) // RQ3
      else $error("jump touched a flag");

   property p_jump_flush;
      @(posedge clock) disable iff (sys_rst)
         doJumpWr |=> ##1 (!pcLoad && !fileWrEn && !zeroWrEn && !fileRdEn) [*4];
   endproperty
   a_jump_flush : assert property (p_jump_flush) // RQ4
      else $error("second jump cycle not idle");

   property p_flush_span;
      @(posedge clock) disable iff (sys_rst)
         pcLoad |-> flushCycle ##4 !flushCycle;
   endproperty
   a_flush_span : assert property (p_flush_span) // RQ4
      else $error("discard not exactly one cycle");

   property p_inc_decode;
      @(posedge clock) disable iff (sys_rst)
         doIncWr |-> instrHeld[13:8] == 6'h0a;
   endproperty
   a_inc_decode : assert property (p_inc_decode) // RQ5
      else $error("increment decode wrong");

   property p_read_addr;
      @(posedge clock) disable iff (sys_rst)
         fileRdEn |-> fileAddr == $past(instrWord[6:0])
                      && $past(instrWord[13:8]) == 6'h0a;
   endproperty
   a_read_addr : assert property (p_read_addr) // RQ5
      else $error("register read not from fetched increment");

   property p_inc_dest;
      @(posedge clock) disable iff (sys_rst)
         doIncWr |=> fileWrEn == $past(destFile)
                     && (fileWrEn || workReg == $past(incResult));
   endproperty
   a_inc_dest : assert property (p_inc_dest) // RQ6
      else $error("increment destination wrong");

   property p_inc_operand;
      @(posedge clock) disable iff (sys_rst)
         doIncWr |-> incResult == $past(fileRdData, 2) + 8'h01;
   endproperty
   a_inc_operand : assert property (p_inc_operand) // RQ6
      else $error("increment result not read value plus one");

   property p_inc_zero;
      @(posedge clock) disable iff (sys_rst)
         doIncWr |=> zeroWrEn && zeroFlag == ($past(incResult) == 8'h00);
   endproperty
   a_inc_zero : assert property (p_inc_zero) // RQ7
      else $error("zero flag wrong");

   property p_inc_one;
      @(posedge clock) disable iff (sys_rst)
         fileRdEn |-> ##2 doIncWr;
   endproperty
   a_inc_one : assert property (p_inc_one) // RQ8
      else $error("increment not in one cycle");

   property p_cycle;
      @(posedge clock) disable iff (sys_rst)
         quarterPhaseOne |=> !quarterPhaseOne [*3] ##1 quarterPhaseOne;
   endproperty
   a_cycle : assert property (p_cycle) // RQ9
      else $error("quarter phase marker period wrong");

   // main scenarios
   c_jump : cover property (@(posedge clock) disable iff (sys_rst) doJumpWr);
   c_inc_w : cover property (@(posedge clock) disable iff (sys_rst) doIncWr && !destFile);
   c_inc_f : cover property (@(posedge clock) disable iff (sys_rst) doIncWr && destFile);
   c_wrap : cover property (@(posedge clock) disable iff (sys_rst) zeroWrEn && zeroFlag);
   c_discard : cover property (@(posedge clock) disable iff (sys_rst) flushCycle && inWrite);
endmodule : jie_exec

// ---- dv/jie_regfile_model.sv ----
// register file model on the far side of the execution block
`timescale 1ns/10ps
module jie_regfile_model (
   input  wire logic       clock,
   input  wire logic [6:0] fileAddr,
   input  wire logic       fileRdEn,
   input  wire logic [7:0] fileWrData,
   input  wire logic       fileWrEn,
   output logic [7:0]      fileRdData
);
   logic [7:0] mem [128];
   logic [7:0] lastVal = 8'h00;
   // released bus shows the inverse, so a late sample never sees stale data
   assign fileRdData = fileRdEn ? mem[fileAddr] : ~lastVal;
   always @(posedge clock) begin
      if (fileRdEn) lastVal <= mem[fileAddr];
      if (fileWrEn) mem[fileAddr] <= fileWrData;
   end
endmodule : jie_regfile_model

// ---- dv/jump_and_increment_exec_bench.sv ----
// self-checking bench for the jump and increment execution block
`timescale 1ns/10ps
module jump_and_increment_exec_bench;
   logic        clock = 1'b0, sys_rst = 1'b1;
   logic [13:0] instrWord = 14'h0000;
   logic [7:0]  pcHighLatch = 8'h00, fileRdData, fileWrData, workReg;
   logic [6:0]  fileAddr;
   logic [12:0] pcValue;
   logic        fileRdEn, fileWrEn, zeroFlag, zeroWrEn, pcLoad, fetchFlush, qOne, cStart;
   int          error_cnt = 0, tests_run = 0;
   jie_exec DUT (.clock(clock), .sys_rst(sys_rst), .instrWord(instrWord),
      .pcHighLatch(pcHighLatch), .fileRdData(fileRdData), .fileAddr(fileAddr),
      .fileRdEn(fileRdEn), .fileWrData(fileWrData), .fileWrEn(fileWrEn),
      .workReg(workReg), .zeroFlag(zeroFlag), .zeroWrEn(zeroWrEn), .pcValue(pcValue),
      .pcLoad(pcLoad), .fetchFlush(fetchFlush), .quarterPhaseOne(qOne), .cycleStart(cStart));
   jie_regfile_model partner (.clock(clock), .fileAddr(fileAddr), .fileRdEn(fileRdEn),
      .fileWrData(fileWrData), .fileWrEn(fileWrEn), .fileRdData(fileRdData));
   initial begin
      forever #25 clock = ~clock;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // one instruction cycle; returns at the falling edge after its fourth quarter
   task automatic run(input logic [13:0] w);
      instrWord = w;
      repeat (4) @(posedge clock);
      @(negedge clock);
   endtask : run
   task automatic t_incw;
      partner.mem[7'h7f] = 8'hff;
      run({6'h0a, 1'b0, 7'h7f});
      check(workReg, 8'h00);
      check(zeroFlag, 1'b1);
      check(zeroWrEn, 1'b1);
      check(fileWrEn, 1'b0);
      partner.mem[7'h05] = 8'h3c;
      run({6'h0a, 1'b0, 7'h05});
      check(workReg, 8'h3d);
      check(zeroFlag, 1'b0);
      $display("test increment to working register done");
   endtask : t_incw
   task automatic t_increment_register;
      partner.mem[7'h00] = 8'h41;
      run({6'h0a, 1'b1, 7'h00});
      check(fileWrEn, 1'b1);
      check(fileWrData, 8'h42);
      check(zeroFlag, 1'b0);
      check(workReg, 8'h3d);
      $display("test increment back to file done");
   endtask : t_increment_register
   task automatic t_jump;
      pcHighLatch = 8'he7;
      run({3'h5, 11'h5a5});
      check(pcLoad, 1'b1);
      check(fetchFlush, 1'b1);
      check(pcValue, {2'b00, 11'h5a5});
      pcHighLatch = 8'h10;
      // this jump falls in the discarded cycle and must not move the pc
      run({3'h5, 11'h2c3});
      check(pcLoad, 1'b0);
      check(pcValue, {2'b00, 11'h5a5});
      run({3'h5, 11'h2c3});
      check(pcValue, {2'b10, 11'h2c3});
      check(fetchFlush, 1'b1);
      check(zeroWrEn, 1'b0);
      run({6'h0a, 1'b1, 7'h00});
      check(fileWrEn, 1'b0);
      check(partner.mem[7'h00], 8'h42);
      run({6'h0a, 1'b1, 7'h00});
      // idle word, so the edge that lands the write starts nothing new
      instrWord = 14'h0000;
      @(negedge clock);
      check(partner.mem[7'h00], 8'h43);
      $display("test jump and discard done");
   endtask : t_jump
   task automatic t_phase;
      int n;
      n = 0;
      while (qOne !== 1'b1) @(negedge clock);
      do begin
         @(negedge clock);
         n++;
      end while (qOne !== 1'b1);
      check(n, 4);
      check(cStart, 1'b1);
      $display("test quarter phase period done");
   endtask : t_phase
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : summarize
   initial begin
      repeat (6) @(posedge clock);
      @(negedge clock);
      sys_rst = 1'b0;
      run(14'h3fff);
      check(pcLoad | fileWrEn | zeroWrEn, 1'b0);
      t_incw();
      t_increment_register();
      t_jump();
      t_phase();
      summarize();
   end
   initial begin
      #20us;
      error_cnt++;
      summarize();
   end
endmodule : jump_and_increment_exec_bench
